/* File: cmd_device.sv */
`timescale 1ns/10ps
module cmd_device #(
    parameter int PINS  = cmd_link_pkg::PIN_COUNT,
    parameter int CHANS = cmd_link_pkg::CHAN_COUNT
) (
    input  wire logic                                         clk,
    input  wire logic                                         rst_n,
    cmd_link_if.device                                        link,
    input  wire logic [PINS-1:0]                              pin_out_cfg,
    input  wire logic [PINS-1:0]                              pin_out_val,
    output logic      [PINS-1:0]                              io_o,
    output logic      [PINS-1:0]                              io_oe,
    output logic      [PINS-1:0]                              od_sel,
    output logic      [PINS-1:0]                              float_sel,
    output logic      [CHANS-1:0][cmd_link_pkg::CODE_BITS-1:0] dac_code,
    output logic                                              dac_load,
    output logic      [cmd_link_pkg::CHAN_BITS-1:0]           dac_chan,
    output logic                                              soft_reset
);

    // Word width used by both clock domains
    localparam int WB = cmd_link_pkg::WORD_BITS;

    // ==========================================================
    // Link domain state
    // ==========================================================
    typedef struct packed {
        logic [WB-2:0] shreg;    // Bits gathered so far
        logic [WB-1:0] word;     // Last whole word
        logic          tgl;      // Flips once per whole word
    } link_state_t;

    // Link clock registers, cleared by the core reset
    link_state_t     lnk_r;      // Link registers
    link_state_t     lnk_nxt;    // Next link registers
    // Counter kept outside the struct: select high clears it on its own
    logic [4:0]      bits_r;     // Bits seen in this frame
    logic [4:0]      bits_nxt;   // Next bit count

    // Bit counter restarts with each frame, so partial words are dropped
    // Select high clears it at once, with no link clock edge needed
    always_ff @(posedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            bits_r <= 5'h00;
        end else begin
            bits_r <= bits_nxt;
        end
    end

    // Shift in on the rising link edge; bits past sixteen are ignored
    always_comb begin
        // Hold everything unless a bit is taken
        lnk_nxt  = lnk_r;
        bits_nxt = bits_r;
        if (bits_r < 5'(WB)) begin
            bits_nxt      = bits_r + 5'h01;
            lnk_nxt.shreg = {lnk_r.shreg[WB-3:0], link.mosi};
            // The sixteenth bit completes the word and flips the toggle
            if (bits_r == 5'(WB - 1)) begin
                lnk_nxt.word = {lnk_r.shreg, link.mosi};
                lnk_nxt.tgl  = ~lnk_r.tgl;
            end
        end
    end

    // Link domain registers
    // The toggle starts equal to the core's copy of it after reset
    always_ff @(posedge link.sclk or negedge rst_n) begin
        if (!rst_n) begin
            lnk_r <= '0;
        end else begin
            lnk_r <= lnk_nxt;
        end
    end

    // ==========================================================
    // Core domain state
    // ==========================================================
    typedef struct packed {
        logic [2:0]                               sync;   // Toggle synchroniser and delay
        logic [PINS-1:0]                          od;     // open_drain_select
        logic [PINS-1:0]                          flt;    // pin_float_select
        logic [CHANS-1:0][cmd_link_pkg::CODE_BITS-1:0] code; // Converter input codes
        logic                                     load;   // Code load pulse
        logic [cmd_link_pkg::CHAN_BITS-1:0]       chan;   // Channel of last load
        logic                                     srst;   // Soft reset pulse
        logic [PINS-1:0]                          po;     // Pin drive values
        logic [PINS-1:0]                          poe;    // Pin drive enables
    } core_state_t;

    core_state_t     core_r;     // Core registers
    core_state_t     core_nxt;   // Next core registers
    logic [PINS-1:0] drv_o;      // Pin value from settings
    logic [PINS-1:0] drv_oe;     // Pin enable from settings
    logic            new_word;   // A whole word has crossed over
    // Read across domains only while the word is known to be still
    logic [WB-1:0]   cmd;        // Word being decoded

    // Per pin drive from float, drain and output settings
    // Float wins over every other setting; a pin that is not a
    // digital output is left undriven for the other functions
    genvar p;
    generate
        for (p = 0; p < PINS; p++) begin : g_pin
            always_comb begin
                if (core_r.flt[p]) begin
                    drv_o[p]  = 1'b0;
                    drv_oe[p] = 1'b0;
                end else if (pin_out_cfg[p]) begin
                    // Open drain only pulls low; a one releases the pin
                    if (core_r.od[p]) begin
                        drv_o[p]  = 1'b0;
                        drv_oe[p] = ~pin_out_val[p];
                    end else begin
                        drv_o[p]  = pin_out_val[p];
                        drv_oe[p] = 1'b1;
                    end
                end else begin
                    drv_o[p]  = 1'b0;
                    drv_oe[p] = 1'b0;
                end
            end
        end
    endgenerate

    // The word stays still for many link clocks after the toggle flips
    // Only the second and third flip-flops feed the decode
    assign new_word = core_r.sync[2] ^ core_r.sync[1];
    assign cmd      = lnk_r.word;

    // Decode each new word and apply it
    always_comb begin
        core_nxt      = core_r;
        core_nxt.sync = {core_r.sync[1:0], lnk_r.tgl};
        // Pulses last a single core cycle
        core_nxt.load = 1'b0;
        core_nxt.srst = 1'b0;
        core_nxt.po   = drv_o;
        core_nxt.poe  = drv_oe;
        if (new_word) begin
            // Top bit set: converter load of one channel
            if (cmd[cmd_link_pkg::TYPE_BIT]) begin
                core_nxt.chan = cmd[cmd_link_pkg::CHAN_HI:cmd_link_pkg::CHAN_LO];
                core_nxt.code[cmd[cmd_link_pkg::CHAN_HI:cmd_link_pkg::CHAN_LO]] =
                    cmd[cmd_link_pkg::CODE_HI:0];
                core_nxt.load = 1'b1;
            end else begin
                // Top bit clear: register select in the next four bits
                unique case (cmd[cmd_link_pkg::SEL_HI:cmd_link_pkg::SEL_LO])
                    cmd_link_pkg::SEL_OPEN_DRAIN: begin
                        core_nxt.od = cmd[PINS-1:0];
                    end
                    cmd_link_pkg::SEL_PIN_FLOAT: begin
                        core_nxt.flt = cmd[PINS-1:0];
                    end
                    cmd_link_pkg::SEL_SOFT_RESET: begin
                        // A wrong key leaves every setting as it was
                        if (cmd[cmd_link_pkg::KEY_HI:0] == cmd_link_pkg::RESET_KEY) begin
                            // Keyed reset returns selections and codes to zero
                            core_nxt.od   = cmd_link_pkg::PIN_RESET_VAL;
                            core_nxt.flt  = cmd_link_pkg::PIN_RESET_VAL;
                            core_nxt.code = '0;
                            core_nxt.srst = 1'b1;
                        end
                    end
                    default: begin
                        // Other selects belong to blocks outside this one
                    end
                endcase
            end
        end
    end

    // Core domain registers
    // Reset leaves every pin released and every code at zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_r <= '0;
        end else begin
            core_r <= core_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // Every output comes straight from a core flip-flop
    assign io_o       = core_r.po;
    assign io_oe      = core_r.poe;
    assign od_sel     = core_r.od;
    assign float_sel  = core_r.flt;
    assign dac_code   = core_r.code;
    assign dac_load   = core_r.load;
    assign dac_chan   = core_r.chan;
    assign soft_reset = core_r.srst;

endmodule

/* File: cmd_link_pkg.sv */
package cmd_link_pkg;

    // ==========================================================
    // Command word layout
    // ==========================================================
    localparam int          WORD_BITS    = 16;          // Bits in one command word
    localparam int          PIN_COUNT    = 8;           // Configurable pins
    localparam int          CHAN_COUNT   = 8;           // Converter channels
    localparam int          CODE_BITS    = 12;          // Converter code width
    localparam int          CHAN_BITS    = 3;           // Channel select width
    localparam int          TYPE_BIT     = 15;          // Set for converter load
    localparam int          SEL_HI       = 14;          // Register select field top
    localparam int          SEL_LO       = 11;          // Register select field bottom
    localparam int          CHAN_HI      = 14;          // Channel field top
    localparam int          CHAN_LO      = 12;          // Channel field bottom
    localparam int          CODE_HI      = 11;          // Code field top
    localparam int          KEY_HI       = 10;          // Reset key field top
    localparam int          SEL_BITS     = 4;           // Register select width
    localparam int          KEY_BITS     = 11;          // Reset key width
    localparam int          RSVD_BITS    = 3;           // Reserved bits 10..8

    // ==========================================================
    // Register selects and key
    // ==========================================================
    localparam logic [3:0]  SEL_OPEN_DRAIN = 4'hC;      // open_drain_select
    localparam logic [3:0]  SEL_PIN_FLOAT  = 4'hD;      // pin_float_select
    localparam logic [3:0]  SEL_SOFT_RESET = 4'hF;      // soft_reset_command
    localparam logic [10:0] RESET_KEY      = 11'h5AC;   // 10110101100
    localparam logic [7:0]  PIN_RESET_VAL  = 8'h00;     // Selection reset value
    localparam logic [2:0]  RSVD_VAL       = 3'h0;      // Reserved bits value

    // ==========================================================
    // Host register map (software side)
    // ==========================================================
    localparam int          ADDR_BITS    = 4;           // Software address width
    localparam logic [3:0]  REG_OD_SET   = 4'h0;        // Write: send drain selection
    localparam logic [3:0]  REG_FLT_SET  = 4'h1;        // Write: send float selection
    localparam logic [3:0]  REG_RESET    = 4'h2;        // Write: send keyed reset
    localparam logic [3:0]  REG_LOAD     = 4'h3;        // Write: send converter load
    localparam logic [3:0]  REG_STATUS   = 4'h4;        // Read: bit 0 busy
    localparam logic [3:0]  REG_LAST     = 4'h5;        // Read: last word sent

    // ==========================================================
    // Link timing
    // ==========================================================
    localparam int          CLK_PERIOD_NS = 8;          // Host clock period
    localparam int          SCLK_HALF_NS  = 64;         // Least half period of link clock
    localparam int          SCLK_HALF_CYC =
        (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

/* File: cmd_link_if.sv */
`timescale 1ns/10ps
// Serial command link: host makes the clock, select and data
interface cmd_link_if;
    logic sclk;      // Link clock, idle low
    logic cs_n;      // Frame select, active low
    logic mosi;      // Command data, MSB first

    modport host   (output sclk, output cs_n, output mosi);
    modport device (input sclk, input cs_n, input mosi);
endinterface

/* File: cmd_host.sv */
`timescale 1ns/10ps
module cmd_host #(
    parameter int HALF_CYC = cmd_link_pkg::SCLK_HALF_CYC
) (
    input  wire logic                               clk,
    input  wire logic                               rst_n,
    cmd_link_if.host                                link,
    input  wire logic [cmd_link_pkg::ADDR_BITS-1:0] addr,
    input  wire logic [15:0]                        wdata,
    input  wire logic                               wr,
    input  wire logic                               rd,
    output logic      [15:0]                        rdata
);

    localparam int WB = cmd_link_pkg::WORD_BITS;

    // ==========================================================
    // State
    // ==========================================================
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,    // Waiting for a command
        ST_SHIFT = 2'b01,    // Clocking the word out
        ST_TAIL  = 2'b10,    // Hold select after last edge
        ST_GAP   = 2'b11     // Select high before next frame
    } host_st_t;

    typedef struct packed {
        host_st_t      st;       // Sequencer state
        logic [7:0]    div;      // Half period divider
        logic [4:0]    bits;     // Bits sent
        logic [WB-1:0] sh;       // Word being sent
        logic [WB-1:0] last;     // Last word accepted
        logic          sclk;     // Link clock out
        logic          cs_n;     // Select out
        logic          mosi;     // Data out
        logic [15:0]   rdata;    // Read data
    } host_state_t;

    host_state_t   s_r;          // Registers
    host_state_t   s_nxt;        // Next registers
    logic          half_done;    // Half period elapsed
    logic          take;         // Command accepted
    logic [WB-1:0] word;         // Word built from the write

    // Build the command word from the register written
    always_comb begin
        take = 1'b0;
        word = '0;
        if (wr && s_r.st == ST_IDLE) begin
            take = 1'b1;
            unique case (addr)
                cmd_link_pkg::REG_OD_SET:
                    word = {1'b0, cmd_link_pkg::SEL_OPEN_DRAIN,
                            cmd_link_pkg::RSVD_VAL, wdata[7:0]};
                cmd_link_pkg::REG_FLT_SET:
                    word = {1'b0, cmd_link_pkg::SEL_PIN_FLOAT,
                            cmd_link_pkg::RSVD_VAL, wdata[7:0]};
                cmd_link_pkg::REG_RESET:
                    word = {1'b0, cmd_link_pkg::SEL_SOFT_RESET,
                            cmd_link_pkg::RESET_KEY};
                cmd_link_pkg::REG_LOAD:
                    word = {1'b1, wdata[14:0]};
                default:
                    take = 1'b0;
            endcase
        end
    end

    assign half_done = (s_r.div == 8'(HALF_CYC - 1));

    // Sequencer: select low, sixteen clock pulses, data changes on fall
    always_comb begin
        s_nxt       = s_r;
        s_nxt.div   = half_done ? 8'h00 : s_r.div + 8'h01;
        s_nxt.rdata = 16'h0000;
        if (rd) begin
            if (addr == cmd_link_pkg::REG_STATUS) begin
                s_nxt.rdata = {15'h0000, s_r.st != ST_IDLE};
            end else if (addr == cmd_link_pkg::REG_LAST) begin
                s_nxt.rdata = s_r.last;
            end
        end
        unique case (s_r.st)
            ST_IDLE: begin
                s_nxt.div = 8'h00;
                if (take) begin
                    s_nxt.st   = ST_SHIFT;
                    s_nxt.sh   = word;
                    s_nxt.last = word;
                    s_nxt.bits = 5'h00;
                    s_nxt.cs_n = 1'b0;
                    s_nxt.mosi = word[WB-1];
                end
            end
            ST_SHIFT: begin
                if (half_done) begin
                    s_nxt.sclk = ~s_r.sclk;
                    if (s_r.sclk) begin
                        if (s_r.bits == 5'(WB - 1)) begin
                            s_nxt.st = ST_TAIL;
                        end else begin
                            s_nxt.bits = s_r.bits + 5'h01;
                            s_nxt.sh   = {s_r.sh[WB-2:0], 1'b0};
                            s_nxt.mosi = s_r.sh[WB-2];
                        end
                    end
                end
            end
            ST_TAIL: begin
                if (half_done) begin
                    s_nxt.cs_n = 1'b1;
                    s_nxt.mosi = 1'b0;
                    s_nxt.st   = ST_GAP;
                end
            end
            ST_GAP: begin
                if (half_done) begin
                    s_nxt.st = ST_IDLE;
                end
            end
        endcase
    end

    // Registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r      <= '0;
            s_r.cs_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign link.sclk = s_r.sclk;
    assign link.cs_n = s_r.cs_n;
    assign link.mosi = s_r.mosi;
    assign rdata     = s_r.rdata;

endmodule

/* File: cmd_link_monitor.sv */
`timescale 1ns/10ps
// ==========================================================
// Wire checker for the command link, sampled on the core clock
// ==========================================================
module cmd_link_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi
);
    // Helper state: link clock history, bit count and shifted word
    typedef struct packed {
        logic        sclk_q;  // Link clock seen one cycle ago
        logic [4:0]  cnt;     // Bits taken in this frame
        logic [15:0] word;    // Bits shifted in, first bit on top
    } mon_t;
    mon_t st_r;               // Registered helper state
    mon_t st_nxt;             // Next helper state

    // Takes a bit on each link clock rise inside a frame
    always_comb begin
        st_nxt = st_r;
        st_nxt.sclk_q = sclk;
        if (cs_n) begin
            st_nxt.cnt = 5'h00;
        end else if (sclk && !st_r.sclk_q) begin
            st_nxt.cnt  = st_r.cnt + 5'h01;
            st_nxt.word = {st_r.word[14:0], mosi};
        end
    end

    // Registers the helper state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // Frame steps
    // ==========================================================
    sequence s_open;
        $fell(cs_n);
    endsequence
    sequence s_close;
        $rose(cs_n);
    endsequence

    property p_idle_low;
        cs_n |-> !sclk;
    endproperty
    property p_first_rise;
        s_open |-> !sclk ##[1:40] $rose(sclk);
    endproperty
    property p_frame_len;
        s_open |-> ##[60:400] $rose(cs_n);
    endproperty
    property p_sixteen;
        s_close |-> (st_r.cnt == 5'h10);
    endproperty
    property p_sel_legal;
        s_close and !st_r.word[15] |-> st_r.word[14:11] inside {4'hC, 4'hD, 4'hF};
    endproperty
    property p_rsvd_zero;
        s_close and !st_r.word[15] and st_r.word[14:12] == 3'h6 |-> st_r.word[10:8] == 3'h0;
    endproperty
    property p_data_hold;
        (!cs_n && sclk) |-> $stable(mosi);
    endproperty
    property p_high_span;
        $rose(sclk) |=> sclk;
    endproperty
    property p_low_span;
        $fell(sclk) && !cs_n |=> !sclk;
    endproperty

    a_idle_low:   assert property (p_idle_low)
        else $error("link clock runs outside a frame");
    a_first_rise: assert property (p_first_rise)
        else $error("frame opens without a clock rise");
    a_frame_len:  assert property (p_frame_len)
        else $error("frame length out of bounds");
    a_sixteen:    assert property (p_sixteen)
        else $error("frame did not carry 16 bits");
    a_sel_legal:  assert property (p_sel_legal)
        else $error("illegal register select sent");
    a_rsvd_zero:  assert property (p_rsvd_zero)
        else $error("reserved bits sent nonzero");
    a_data_hold:  assert property (p_data_hold)
        else $error("data moved while clock high");
    a_high_span:  assert property (p_high_span)
        else $error("link clock high too short");
    a_low_span:   assert property (p_low_span)
        else $error("link clock low too short");
endmodule

/* File: tb.sv */
`timescale 1ns/10ps
module tb;
    // ==========================================================
    // Stimulus and observed signals
    // ==========================================================
    logic        clk = 1'b0;        // Core clock
    logic        rst_n = 1'b1;      // Reset, active low, pulled low at start
    logic [3:0]  addr = 4'h0;       // Software address
    logic [15:0] wdata = 16'h0000;  // Software write data
    logic        wr = 1'b0;         // Write strobe
    logic        rd = 1'b0;         // Read strobe
    logic [15:0] rdata;             // Read data
    logic [7:0]  cfg = 8'h00;       // Pins set as digital outputs
    logic [7:0]  val = 8'h00;       // Digital output values
    logic [7:0]  io_o, io_oe, od_sel, float_sel, od2;
    logic [7:0][11:0] dac_code;     // Converter codes
    logic        dac_load, soft_reset;
    logic        srst2;             // Soft reset pulse, second device
    logic [2:0]  dac_chan;          // Last loaded channel
    logic [15:0] cap, wire_word;    // Word seen on the wire
    logic [15:0] d;                 // Read scratch
    int          mismatches = 0;
    int          samples_checked = 0;
    int          loads = 0, resets = 0, resets2 = 0;

    always #4 clk = ~clk;
    cmd_link_if lk ();
    cmd_link_if lk2 ();
    cmd_host #(.HALF_CYC(2)) cmd_host_inst (.clk(clk), .rst_n(rst_n), .link(lk.host),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    cmd_device cmd_device_inst (.clk(clk), .rst_n(rst_n), .link(lk.device),
        .pin_out_cfg(cfg), .pin_out_val(val), .io_o(io_o), .io_oe(io_oe), .od_sel(od_sel),
        .float_sel(float_sel), .dac_code(dac_code), .dac_load(dac_load),
        .dac_chan(dac_chan), .soft_reset(soft_reset));
    // Second device faces a driver that sends frames of 15, 16 and 17 bits
    cmd_device cmd_device_inst2 (.clk(clk), .rst_n(rst_n), .link(lk2.device),
        .pin_out_cfg(cfg), .pin_out_val(val), .io_o(), .io_oe(), .od_sel(od2),
        .float_sel(), .dac_code(), .dac_load(), .dac_chan(), .soft_reset(srst2));
    cmd_link_monitor cmd_link_monitor_inst (.clk(clk), .rst_n(rst_n), .sclk(lk.sclk),
        .cs_n(lk.cs_n), .mosi(lk.mosi));

    // Captures the word on the wire, first bit on top
    always @(posedge lk.sclk) if (lk.cs_n === 1'b0) cap <= {cap[14:0], lk.mosi};
    always @(posedge lk.cs_n) wire_word <= cap;
    // Counts one-cycle pulses
    always @(posedge clk) begin
        if (dac_load === 1'b1) loads++;
        if (soft_reset === 1'b1) resets++;
        if (srst2 === 1'b1) resets2++;
    end

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    // Writes a command, polls until idle, lets the device settle
    task automatic send(input logic [3:0] a, input logic [15:0] v);
        logic [15:0] s;
        int i;
        wr_reg(a, v);
        for (i = 0; i < 400; i++) begin
            rd_reg(cmd_link_pkg::REG_STATUS, s);
            if (s[0] === 1'b0) break;
        end
        if (i == 400) begin
            mismatches++;
            tally_and_finish();
        end
        repeat (6) @(posedge clk);
        #1;
    endtask

    // Pin drive expected from drain, float and output settings
    task automatic chk_io(input logic [7:0] od, input logic [7:0] fl);
        logic [7:0] oe, o;
        for (int i = 0; i < 8; i++) begin
            oe[i] = !fl[i] && cfg[i] && !(od[i] && val[i]);
            o[i] = oe[i] && !od[i] && val[i];
        end
        check("io", {oe, o}, {io_oe, io_o & io_oe});
    endtask

    // Drives n bits of a word on the second link, 125 ns clock
    task automatic bang(input logic [15:0] w, input int n);
        lk2.cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            lk2.mosi = w[15 - (i % 16)];
            #62.5 lk2.sclk = 1'b1;
            #62.5 lk2.sclk = 1'b0;
        end
        #62.5 lk2.cs_n = 1'b1;
        lk2.mosi = ~lk2.mosi;
        repeat (10) @(posedge clk);
        #1;
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        // Driven after time zero so that every reset edge is seen
        rst_n    <= 1'b0;
        lk2.sclk <= 1'b0;
        lk2.cs_n <= 1'b1;
        lk2.mosi <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        cfg <= 8'h0F;
        val <= 8'h33;
        #1;
        check("od_sel", 16'h0000, {8'h00, od_sel});
        check("float_sel", 16'h0000, {8'h00, float_sel});
        send(cmd_link_pkg::REG_OD_SET, 16'h00A5);
        check("wire", 16'h60A5, wire_word);
        check("od_sel", 16'h00A5, {8'h00, od_sel});
        chk_io(8'hA5, 8'h00);
        send(cmd_link_pkg::REG_FLT_SET, 16'hFF3C);
        check("wire", 16'h683C, wire_word);
        check("float_sel", 16'h003C, {8'h00, float_sel});
        chk_io(8'hA5, 8'h3C);
        rd_reg(cmd_link_pkg::REG_LAST, d);
        check("last", 16'h683C, d);
        rd_reg(4'h9, d);
        check("unmapped", 16'h0000, d);
        wr_reg(4'h7, 16'h1234);
        rd_reg(cmd_link_pkg::REG_STATUS, d);
        check("busy", 16'h0000, d);
        for (int c = 0; c < 8; c++) begin
            send(cmd_link_pkg::REG_LOAD, {1'b1, c[2:0], 12'hF0F ^ (c[11:0] * 12'h111)});
            check("wire", {1'b1, c[2:0], 12'hF0F ^ (c[11:0] * 12'h111)}, wire_word);
            check("code", {4'h0, 12'hF0F ^ (c[11:0] * 12'h111)}, {4'h0, dac_code[c]});
            check("chan", {13'h0000, c[2:0]}, {13'h0000, dac_chan});
        end
        check("loads", 16'h0008, loads[15:0]);
        // The host always sends the true key, so a wrong key goes by the second link
        bang(16'h60A5, 16);
        check("od2", 16'h00A5, {8'h00, od2});
        bang(16'h7DAD, 16);
        check("od2", 16'h00A5, {8'h00, od2});
        check("resets2", 16'h0000, resets2[15:0]);
        send(cmd_link_pkg::REG_RESET, 16'h05AC);
        check("wire", 16'h7DAC, wire_word);
        check("resets", 16'h0001, resets[15:0]);
        check("od_sel", 16'h0000, {8'h00, od_sel});
        check("float_sel", 16'h0000, {8'h00, float_sel});
        check("code", 16'h0000, {4'h0, dac_code[7]});
        chk_io(8'h00, 8'h00);
        bang(16'h60FF, 15);
        check("od2", 16'h00A5, {8'h00, od2});
        bang(16'h60FF, 16);
        check("od2", 16'h00FF, {8'h00, od2});
        bang(16'h6011, 17);
        check("od2", 16'h0011, {8'h00, od2});
        bang(16'h7DAC, 16);
        check("resets2", 16'h0001, resets2[15:0]);
        tally_and_finish();
    end

    // Cuts a hang short
    initial begin
        #500000;
        mismatches++;
        tally_and_finish();
    end
endmodule
